/* File: rtl/hdlc_fifo_host_control.v */
// Host-side receive and transmit FIFO control of an HDLC controller.
// Assumes receiver and transmitter byte engines on the same clock.
// Behaviour
// - overflowed frame gets data-overflow flag in status
// - full buffer at frame start: discard, lost irq
// - overreads repeat last data, never corrupt
// - acknowledge discards block even when unread
// - status byte closes every stored frame
// - status bits masked by address mode
// - twelve-bit frame byte count plus overflow bit
// - 64-byte transmit store, 16/32 block, default 32
// - pool-ready after reset command or freed block
// - underrun aborts frame with seven ones, irq
// - late collision stops transmitter, repeat irq
// - underrun/repeat clear buffer, raise pool-ready too
// - writes ignored while underrun/repeat pending
// - frame command sends block, opening flag automatic
// - message end appends check sequence, closing flag
// - transmitter reset clears, aborts, keeps irqs
// - overflow flag when host exceeds block size
// - write-enable flag shows block may be written
// - combined command locks until closing flag
// - frame/end command: pool-ready on free block
// - pool-ready at 48 or 32 bytes queued
// - block size changes only at commands
// - acknowledge frees space, resets count at end
// - pool-full irq for block of unfinished frame
//
// Decided for this implementation: the address-and-strobe port and the address map.
`include "hdlc_fifo_defines.vh"
`default_nettype none

module hdlc_fifo_host_control (
    input  wire       core_clk_i,
    input  wire       rst_i,
    input  wire [3:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    output reg  [7:0] reg_rdata_o,
    input  wire       rx_start_i,
    input  wire       rx_byte_valid_i,
    input  wire [7:0] rx_byte_i,
    input  wire       rx_end_i,
    input  wire       rx_crc_ok_i,
    input  wire       rx_valid_frame_i,
    input  wire       rx_abort_i,
    input  wire       rx_cr_i,
    input  wire [1:0] rx_sapi_match_i,
    input  wire       rx_tei_match_i,
    input  wire       tx_req_i,
    input  wire       tx_closing_done_i,
    input  wire       tx_collision_i,
    output reg  [7:0] tx_data_o,
    output reg        tx_valid_o,
    output reg        tx_last_o,
    output reg        tx_abort_o
);

    // ------------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------------
    reg  [7:0]  receive_buffer [0:63];
    reg         rx_end_mark    [0:63];
    reg  [7:0]  transmit_buffer [0:63];
    reg         tx_end_mark    [0:63];
    reg  [7:0]  hdlc_irq_status_reg;
    reg  [7:0]  extended_mode_reg;
    reg  [6:0]  rx_wp;
    reg  [6:0]  rx_base;
    reg  [6:0]  rx_hp;
    reg  [5:0]  rx_len;
    reg         rx_pend;
    reg         rx_is_end;
    reg  [1:0]  rx_bs_act;
    reg         rx_drop;
    reg         rx_data_overflow_flag;
    reg  [11:0] rx_byte_count;
    reg         rx_count_overflow;
    reg  [6:0]  tx_wp;
    reg  [6:0]  tx_rp;
    reg  [6:0]  tx_commit;
    reg  [6:0]  tx_frame_start;
    reg  [6:0]  tx_sent;
    reg  [5:0]  tx_wr_cnt;
    reg         tx_bs_act;
    reg         tx_armed;
    reg         tx_lock;
    reg         tx_in_frame;
    reg         tx_overflow_flag;

    wire [6:0]  rx_used  = rx_wp - rx_base;
    wire [5:0]  rx_blk   = `BLK_MAX >> rx_bs_act;
    wire [5:0]  tx_blk   = tx_bs_act ? `BLK_SMALL_TX : `BLK_MAX;
    wire [6:0]  tx_queued = tx_wp - tx_rp;
    wire        tx_err_pend = hdlc_irq_status_reg[`IRQ_TX_UNDER] |
                              hdlc_irq_status_reg[`IRQ_TX_REPEAT];
    wire        tx_write_enable_flag = !tx_lock && !tx_armed && !tx_err_pend;
    wire        wr_fifo  = reg_wr_i && (reg_addr_i == `REG_FIFO);
    wire        wr_cmd   = reg_wr_i && (reg_addr_i == `REG_COMMAND);
    wire        rd_fifo  = reg_rd_i && (reg_addr_i == `REG_FIFO);
    wire        rd_irq   = reg_rd_i && (reg_addr_i == `REG_IRQ_STATUS);
    wire [2:0]  rx_mode  = extended_mode_reg[`EXT_MODE_HI:0];
    wire        addr_bits_ok = (rx_mode == `MODE_NONAUTO2) || (rx_mode == `MODE_TRANS1);
    wire        tei_ok   = (rx_mode != `MODE_TRANS0) && (rx_mode != `MODE_TRANS1);
    wire [6:0]  rx_limit = rx_pend ? {1'b0, rx_len} : rx_used;
    wire [6:0]  rx_next_hp = rx_hp + 7'h01;

    // ------------------------------------------------------------------
    // Search of a frame end inside the next receive block
    // ------------------------------------------------------------------
    reg         end_found;
    reg  [5:0]  end_len;
    reg  [5:0]  slot;
    integer     i;

    always @*
    begin
        end_found = 1'b0;
        end_len   = 6'h00;
        slot      = 6'h00;
        for (i = 31; i >= 0; i = i - 1)
        begin
            slot = rx_base[5:0] + i[5:0];
            if ((i[5:0] < rx_blk) && ({1'b0, i[5:0]} < rx_used) && rx_end_mark[slot])
            begin
                end_found = 1'b1;
                end_len   = i[5:0] + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status byte assembly
    // ------------------------------------------------------------------
    reg  [7:0]  rx_frame_status_byte;

    always @*
    begin
        rx_frame_status_byte = 8'h00;
        rx_frame_status_byte[`RS_VALID] = rx_valid_frame_i;
        rx_frame_status_byte[`RS_OVF]   = rx_data_overflow_flag;
        rx_frame_status_byte[`RS_CRC]   = rx_crc_ok_i;
        rx_frame_status_byte[`RS_ABORT] = rx_abort_i;
        if (addr_bits_ok)
        begin
            rx_frame_status_byte[`RS_SAPI_HI:`RS_SAPI_LO] = rx_sapi_match_i;
            rx_frame_status_byte[`RS_CR] = rx_cr_i;
        end
        if (tei_ok) rx_frame_status_byte[`RS_TEI] = rx_tei_match_i;
    end

    // ------------------------------------------------------------------
    // Buffer memories
    // ------------------------------------------------------------------
    wire rx_store_data   = rx_byte_valid_i && !rx_drop && (rx_used < `BUF_DATA_LIMIT);
    wire rx_store_status = rx_end_i && !rx_drop;
    wire tx_store        = wr_fifo && !tx_lock && !tx_err_pend;

    always @(posedge core_clk_i)
    begin
        if (rx_store_status)
        begin
            receive_buffer[rx_wp[5:0]] <= rx_frame_status_byte;
            rx_end_mark[rx_wp[5:0]]    <= 1'b1;
        end
        else if (rx_store_data)
        begin
            receive_buffer[rx_wp[5:0]] <= rx_byte_i;
            rx_end_mark[rx_wp[5:0]]    <= 1'b0;
        end
        if (tx_store)
        begin
            transmit_buffer[tx_wp[5:0]] <= reg_wdata_i;
            tx_end_mark[tx_wp[5:0]] <= 1'b0;
        end
        else if (wr_cmd && reg_wdata_i[`CMD_TX_END] && !reg_wdata_i[`CMD_TX_RESET])
        begin
            tx_end_mark[tx_wp[5:0] - 6'h01] <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Control state of both directions and the interrupt status
    // ------------------------------------------------------------------
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            hdlc_irq_status_reg   <= 8'h00;
            extended_mode_reg     <= `EXT_RESET;
            rx_wp                 <= 7'h00;
            rx_base               <= 7'h00;
            rx_hp                 <= 7'h00;
            rx_len                <= 6'h00;
            rx_pend               <= 1'b0;
            rx_is_end             <= 1'b0;
            rx_bs_act             <= 2'h0;
            rx_drop               <= 1'b0;
            rx_data_overflow_flag <= 1'b0;
            rx_byte_count         <= 12'h000;
            rx_count_overflow     <= 1'b0;
            tx_wp                 <= 7'h00;
            tx_rp                 <= 7'h00;
            tx_commit             <= 7'h00;
            tx_frame_start        <= 7'h00;
            tx_sent               <= 7'h00;
            tx_wr_cnt             <= 6'h00;
            tx_bs_act             <= 1'b0;
            tx_armed              <= 1'b0;
            tx_lock               <= 1'b0;
            tx_in_frame           <= 1'b0;
            tx_overflow_flag      <= 1'b0;
            tx_data_o             <= 8'h00;
            tx_valid_o            <= 1'b0;
            tx_last_o             <= 1'b0;
            tx_abort_o            <= 1'b0;
        end
        else
        begin
            tx_valid_o <= 1'b0;
            tx_last_o  <= 1'b0;
            tx_abort_o <= 1'b0;
            if (rd_irq) hdlc_irq_status_reg <= 8'h00;
            if (reg_wr_i && (reg_addr_i == `REG_EXT_MODE)) extended_mode_reg <= reg_wdata_i;

            // Receive write side.
            if (rx_start_i)
            begin
                rx_data_overflow_flag <= 1'b0;
                rx_drop <= (rx_used >= `BUF_DATA_LIMIT);
                if (rx_used >= `BUF_DATA_LIMIT) hdlc_irq_status_reg[`IRQ_RX_LOST] <= 1'b1;
            end
            else if (rx_byte_valid_i && !rx_drop && !rx_store_data)
                rx_data_overflow_flag <= 1'b1;
            if (rx_store_status || rx_store_data) rx_wp <= rx_wp + 7'h01;

            // Receive host side.
            if (rd_fifo && (rx_next_hp - rx_base < rx_limit)) rx_hp <= rx_next_hp;
            if (!rx_pend && end_found)
            begin
                rx_pend   <= 1'b1;
                rx_is_end <= 1'b1;
                rx_len    <= end_len;
                hdlc_irq_status_reg[`IRQ_RX_END] <= 1'b1;
                {rx_count_overflow, rx_byte_count} <= {1'b0, rx_byte_count} +
                    {7'h00, end_len} | {rx_count_overflow, 12'h000};
            end
            else if (!rx_pend && (rx_used >= {1'b0, rx_blk}))
            begin
                rx_pend   <= 1'b1;
                rx_is_end <= 1'b0;
                rx_len    <= rx_blk;
                hdlc_irq_status_reg[`IRQ_RX_POOL] <= 1'b1;
                {rx_count_overflow, rx_byte_count} <= {1'b0, rx_byte_count} +
                    {7'h00, rx_blk} | {rx_count_overflow, 12'h000};
            end
            if (wr_cmd && reg_wdata_i[`CMD_RX_RESET])
            begin
                rx_wp     <= rx_base;
                rx_hp     <= rx_base;
                rx_pend   <= 1'b0;
                rx_drop   <= 1'b1;
                rx_bs_act <= extended_mode_reg[`EXT_RX_BS_HI:`EXT_RX_BS_LO];
                rx_byte_count     <= 12'h000;
                rx_count_overflow <= 1'b0;
            end
            else if (wr_cmd && reg_wdata_i[`CMD_RX_ACK])
            begin
                rx_bs_act <= extended_mode_reg[`EXT_RX_BS_HI:`EXT_RX_BS_LO];
                if (rx_pend)
                begin
                    rx_base <= rx_base + {1'b0, rx_len};
                    rx_hp   <= rx_base + {1'b0, rx_len};
                    rx_pend <= 1'b0;
                    if (rx_is_end)
                    begin
                        rx_byte_count     <= 12'h000;
                        rx_count_overflow <= 1'b0;
                    end
                end
            end

            // Transmit host side.
            if (tx_store)
            begin
                tx_wp <= tx_wp + 7'h01;
                if (tx_wr_cnt >= tx_blk) tx_overflow_flag <= 1'b1;
                else tx_wr_cnt <= tx_wr_cnt + 6'h01;
            end
            if (tx_armed && (tx_queued <= `BUF_BYTES - {1'b0, tx_blk}))
            begin
                tx_armed <= 1'b0;
                hdlc_irq_status_reg[`IRQ_TX_POOL] <= 1'b1;
            end
            if (tx_lock && tx_closing_done_i)
            begin
                tx_lock    <= 1'b0;
                tx_abort_o <= 1'b1;
                hdlc_irq_status_reg[`IRQ_TX_POOL] <= 1'b1;
            end

            // Transmit engine side.
            if (tx_collision_i && tx_in_frame)
            begin
                if (tx_sent >= {1'b0, tx_blk})
                begin
                    hdlc_irq_status_reg[`IRQ_TX_REPEAT] <= 1'b1;
                    hdlc_irq_status_reg[`IRQ_TX_POOL]   <= 1'b1;
                    tx_in_frame <= 1'b0;
                    tx_wp       <= tx_rp;
                    tx_commit   <= tx_rp;
                    tx_armed    <= 1'b0;
                    tx_lock     <= 1'b0;
                end
                else
                begin
                    tx_rp   <= tx_frame_start;
                    tx_sent <= 7'h00;
                end
            end
            else if (tx_req_i && (tx_rp != tx_commit))
            begin
                tx_data_o  <= transmit_buffer[tx_rp[5:0]];
                tx_valid_o <= 1'b1;
                tx_last_o  <= tx_end_mark[tx_rp[5:0]];
                tx_rp      <= tx_rp + 7'h01;
                tx_in_frame <= !tx_end_mark[tx_rp[5:0]];
                tx_sent    <= tx_in_frame ? tx_sent + 7'h01 : 7'h01;
                if (!tx_in_frame) tx_frame_start <= tx_rp;
            end
            else if (tx_req_i && tx_in_frame)
            begin
                tx_abort_o  <= 1'b1;
                hdlc_irq_status_reg[`IRQ_TX_UNDER] <= 1'b1;
                hdlc_irq_status_reg[`IRQ_TX_POOL]  <= 1'b1;
                tx_in_frame <= 1'b0;
                tx_wp       <= tx_rp;
                tx_commit   <= tx_rp;
                tx_armed    <= 1'b0;
                tx_lock     <= 1'b0;
            end

            // Transmit commands; reset takes precedence over earlier updates except tx_last_o, tx_data_o, tx_sent, tx_frame_start and the underrun/repeat irq bits.
            if (wr_cmd && reg_wdata_i[`CMD_TX_RESET])
            begin
                tx_wp       <= 7'h00;
                tx_rp       <= 7'h00;
                tx_commit   <= 7'h00;
                tx_in_frame <= 1'b0;
                tx_armed    <= 1'b0;
                tx_lock     <= 1'b0;
                tx_wr_cnt   <= 6'h00;
                tx_overflow_flag <= 1'b0;
                tx_abort_o  <= 1'b1;
                tx_valid_o  <= 1'b0;
                tx_bs_act   <= extended_mode_reg[`EXT_TX_BS];
                hdlc_irq_status_reg[`IRQ_TX_POOL] <= 1'b1;
            end
            else if (wr_cmd && (reg_wdata_i[`CMD_TX_FRAME] || reg_wdata_i[`CMD_TX_END]))
            begin
                tx_commit <= tx_wp;
                tx_wr_cnt <= 6'h00;
                tx_bs_act <= extended_mode_reg[`EXT_TX_BS];
                if (reg_wdata_i[`CMD_TX_FRAME] && reg_wdata_i[`CMD_TX_END])
                    tx_lock <= 1'b1;
                else
                    tx_armed <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                `REG_FIFO:       reg_rdata_o <= receive_buffer[rx_hp[5:0]];
                `REG_IRQ_STATUS: reg_rdata_o <= hdlc_irq_status_reg;
                `REG_STATUS:     reg_rdata_o <= {1'b0, tx_write_enable_flag, 1'b0,
                                                 tx_overflow_flag, 4'h0};
                `REG_EXT_MODE:   reg_rdata_o <= extended_mode_reg;
                `REG_COUNT_LOW:  reg_rdata_o <= rx_byte_count[7:0];
                `REG_COUNT_HIGH: reg_rdata_o <= {3'h0, rx_count_overflow,
                                                 rx_byte_count[11:8]};
                default:         reg_rdata_o <= 8'h00;
            endcase
        end
    end

endmodule // hdlc_fifo_host_control
`default_nettype wire

/* File: rtl/hdlc_fifo_defines.vh */
// Constants of the HDLC FIFO host control block.
// Assumes inclusion by its bare name from the design files.
`ifndef HDLC_FIFO_DEFINES_VH
`define HDLC_FIFO_DEFINES_VH
// Register map, index on the 4-bit register address.
`define REG_FIFO        4'h0
`define REG_IRQ_STATUS  4'h1
`define REG_STATUS      4'h2
`define REG_COMMAND     4'h3
`define REG_EXT_MODE    4'h4
`define REG_COUNT_LOW   4'h5
`define REG_COUNT_HIGH  4'h6
// Command bits.
`define CMD_RX_ACK      7
`define CMD_RX_RESET    6
`define CMD_TX_FRAME    3
`define CMD_TX_END      1
`define CMD_TX_RESET    0
// Interrupt status bits.
`define IRQ_RX_POOL     7
`define IRQ_RX_END      6
`define IRQ_RX_LOST     5
`define IRQ_TX_POOL     4
`define IRQ_TX_UNDER    2
`define IRQ_TX_REPEAT   1
// Extended mode fields.
`define EXT_TX_BS       7
`define EXT_RX_BS_HI    6
`define EXT_RX_BS_LO    5
`define EXT_MODE_HI     2
`define EXT_RESET       8'h00
// Receive status byte bits.
`define RS_VALID        7
`define RS_OVF          6
`define RS_CRC          5
`define RS_ABORT        4
`define RS_SAPI_HI      3
`define RS_SAPI_LO      2
`define RS_CR           1
`define RS_TEI          0
// Address modes.
`define MODE_NONAUTO2   3'h3
`define MODE_TRANS0     3'h6
`define MODE_TRANS1     3'h7
// Buffer geometry.
`define BUF_BYTES       7'h40
`define BUF_DATA_LIMIT  7'h3F
`define BLK_MAX         6'h20
`define BLK_SMALL_TX    6'h10
`endif

/* File: verif/hdlc_fifo_host_control_chk.sv */
// Concurrent checks on the ports of the HDLC FIFO host control block.
// Assumes the block's defines header and one clock with synchronous reset.
`include "hdlc_fifo_defines.vh"
`default_nettype none
module hdlc_fifo_host_control_chk (
    input wire logic       core_clk_i,
    input wire logic       rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       tx_req_i,
    input wire logic       tx_closing_done_i,
    input wire logic       tx_collision_i,
    input wire logic       tx_valid_o,
    input wire logic       tx_last_o,
    input wire logic       tx_abort_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire tx_reset_cmd_wr = reg_wr_i && reg_addr_i == `REG_COMMAND && reg_wdata_i[`CMD_TX_RESET];
    wire cause   = tx_req_i | tx_collision_i | tx_closing_done_i | tx_reset_cmd_wr;
    wire rd_irq  = reg_rd_i && reg_addr_i == `REG_IRQ_STATUS;
    wire quiet   = !(cause | reg_wr_i);

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    // Two status reads two cycles apart with no transmit event around them.
    sequence s_two_reads;
        quiet [*2] ##1 (quiet && rd_irq) ##1 quiet ##1 (quiet && rd_irq);
    endsequence

    AST_RESET_QUIET: assert property ($past(rst_i) |-> !tx_valid_o && !tx_abort_o
        && reg_rdata_o == 8'h00) else $error("busy after reset");
    AST_VALID_AFTER_REQ: assert property (tx_valid_o |-> $past(tx_req_i))
        else $error("data without request");
    AST_LAST_IN_VALID: assert property (tx_last_o |-> tx_valid_o)
        else $error("last without data");
    AST_ABORT_NO_DATA: assert property (tx_abort_o |-> !tx_valid_o)
        else $error("abort with data");
    AST_ABORT_CAUSE: assert property (tx_abort_o |-> $past(cause) || $past(cause, 2))
        else $error("abort without cause");
    AST_TX_RESET_CMD_ABORT: assert property (tx_reset_cmd_wr |-> ##[1:2] tx_abort_o)
        else $error("reset sent no abort");
    AST_RDATA_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed idle");
    AST_UNMAPPED_ZERO: assert property (reg_rd_i && reg_addr_i > 4'h6 |=>
        reg_rdata_o == 8'h00) else $error("unmapped not zero");
    AST_CLEAR_ON_READ: assert property (s_two_reads |=>
        !reg_rdata_o[`IRQ_TX_UNDER] && !reg_rdata_o[`IRQ_TX_REPEAT])
        else $error("error bits survived read");
endmodule // hdlc_fifo_host_control_chk

bind hdlc_fifo_host_control hdlc_fifo_host_control_chk u_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .tx_req_i(tx_req_i), .tx_closing_done_i(tx_closing_done_i),
    .tx_collision_i(tx_collision_i), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o),
    .tx_abort_o(tx_abort_o)
);
`default_nettype wire

/* File: verif/tx_engine_model.sv */
// Model of the serial transmit engine on the far side of the block.
// Assumes the block's clock; asks for a byte every fourth cycle while enabled.
`default_nettype none
module tx_engine_model (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    output wire logic       req_o,
    input  wire logic [7:0] data_i,
    input  wire logic       valid_i,
    input  wire logic       last_i,
    output var  logic [7:0] data_o,
    output var  logic       last_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pace = 2'h0;

    assign req_o = go_i && pace == 2'h3;

    always @(posedge clk_i)
    begin
        pace <= pace + 2'h1;
        if (valid_i)
        begin
            data_o <= data_i;
            last_o <= last_i;
        end
    end
endmodule // tx_engine_model
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking testbench of the HDLC FIFO host control block.
// Assumes the block, its checker and the transmit engine model are compiled.
`include "hdlc_fifo_defines.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic            clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, go = 1'b0;
    logic            rx_go = 1'b0, rx_bv = 1'b0, rx_end = 1'b0, coll = 1'b0, closing = 1'b0;
    logic [3:0]      addr = 4'h0;
    logic [7:0]      wdata = 8'h00, rx_b = 8'h00;
    logic [6:0]      rxf = 7'h00;
    wire logic [7:0] rdata, tx_data, mdl_data;
    wire logic       tx_req, tx_valid, tx_last, tx_abort, mdl_last;
    int              err_count = 0, checks_done = 0, nev = 0, nabort = 0;

    hdlc_fifo_host_control u_dut (
        .core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .rx_start_i(rx_go),
        .rx_byte_valid_i(rx_bv), .rx_byte_i(rx_b), .rx_end_i(rx_end), .rx_crc_ok_i(rxf[6]),
        .rx_valid_frame_i(rxf[5]), .rx_abort_i(rxf[4]), .rx_cr_i(rxf[3]),
        .rx_sapi_match_i(rxf[2:1]), .rx_tei_match_i(rxf[0]), .tx_req_i(tx_req),
        .tx_closing_done_i(closing), .tx_collision_i(coll), .tx_data_o(tx_data),
        .tx_valid_o(tx_valid), .tx_last_o(tx_last), .tx_abort_o(tx_abort)
    );
    tx_engine_model u_eng (
        .clk_i(clk), .go_i(go), .req_o(tx_req), .data_i(tx_data), .valid_i(tx_valid),
        .last_i(tx_last), .data_o(mdl_data), .last_o(mdl_last)
    );

    initial
    begin
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (tx_valid || tx_abort) nev <= nev + 1;
        if (tx_abort) nabort <= nabort + 1;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                      input string n);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk(n, rdata & m, e);
    endtask

    task automatic cmd(input logic [7:0] v);
        wr(`REG_COMMAND, v);
    endtask

    task automatic clr_irq();
        rc(`REG_IRQ_STATUS, 8'h00, 8'h00, "clr");
    endtask

    task automatic fill(input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++) wr(`REG_FIFO, b + 8'(i));
    endtask

    // Lets the engine take n answers (data bytes or aborts), bounded.
    task automatic send(input int n);
        int t;
        t = nev + n;
        go <= 1'b1;
        for (int i = 0; i < 400 && nev < t; i++) @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // Receives a frame whose data bytes count up from one.
    task automatic rx_frame(input int n);
        @(posedge clk);
        rx_go <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            rx_go <= 1'b0;
            rx_bv <= 1'b1;
            rx_b <= 8'(i + 1);
        end
        @(posedge clk);
        rx_bv <= 1'b0;
        rx_end <= 1'b1;
        @(posedge clk);
        rx_end <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_idle();
        rc(`REG_STATUS, 8'h50, 8'h40, "status_reset");
        rc(`REG_IRQ_STATUS, 8'hFF, 8'h00, "irq_reset");
        rc(`REG_EXT_MODE, 8'hFF, 8'h00, "ext_reset");
        rc(4'hF, 8'hFF, 8'h00, "unmapped");
    endtask

    task automatic t_rx();
        rxf <= 7'h6F;
        rx_frame(4);
        rc(`REG_IRQ_STATUS, 8'h40, 8'h40, "rx_end");
        rc(`REG_COUNT_LOW, 8'hFF, 8'h05, "count_low");
        rc(`REG_COUNT_HIGH, 8'h1F, 8'h00, "count_high");
        for (int i = 1; i < 5; i++) rc(`REG_FIFO, 8'hFF, 8'(i), "rx_data");
        rc(`REG_FIFO, 8'hFF, 8'hA1, "status_mode0");
        rc(`REG_FIFO, 8'hFF, 8'hA1, "overread");
        cmd(8'h80);
        rc(`REG_COUNT_LOW, 8'hFF, 8'h00, "count_cleared");
        wr(`REG_EXT_MODE, 8'h07);
        cmd(8'h40);
        rxf <= 7'h7F;
        rx_frame(2);
        for (int i = 1; i < 3; i++) rc(`REG_FIFO, 8'hFF, 8'(i), "rx_data");
        rc(`REG_FIFO, 8'hFF, 8'hBE, "status_mode7");
        cmd(8'h80);
        clr_irq();
    endtask

    task automatic t_rx_full();
        rx_frame(70);
        rx_frame(1);
        rc(`REG_IRQ_STATUS, 8'hE0, 8'hA0, "pool_and_lost");
        cmd(8'h80);
        for (int i = 33; i < 64; i++) rc(`REG_FIFO, 8'hFF, 8'(i), "after_ack");
        rc(`REG_FIFO, 8'h40, 8'h40, "data_overflow");
        cmd(8'h40);
        clr_irq();
    endtask

    task automatic t_tx();
        fill(3, 8'h11);
        cmd(8'h0A);
        send(3);
        chk("tx_data", mdl_data, 8'h13);
        chk("tx_last", {7'h00, mdl_last}, 8'h01);
        rc(`REG_IRQ_STATUS, 8'h10, 8'h00, "pool_locked");
        @(posedge clk);
        closing <= 1'b1;
        @(posedge clk);
        closing <= 1'b0;
        rc(`REG_IRQ_STATUS, 8'h10, 8'h10, "pool_after_close");
    endtask

    task automatic t_under();
        int a;
        a = nabort;
        fill(1, 8'hC1);
        cmd(8'h08);
        send(2);
        chk("underrun_abort", 8'(nabort - a), 8'h01);
        fill(1, 8'hEE);
        rc(`REG_IRQ_STATUS, 8'h16, 8'h14, "underrun_irq");
        fill(1, 8'h5A);
        cmd(8'h0A);
        send(1);
        chk("locked_write", mdl_data, 8'h5A);
        @(posedge clk);
        closing <= 1'b1;
        @(posedge clk);
        closing <= 1'b0;
        clr_irq();
    endtask

    task automatic t_tx_reset_cmd();
        int a;
        a = nabort;
        cmd(8'h01);
        repeat (3) @(posedge clk);
        chk("reset_abort", 8'(nabort - a), 8'h01);
        rc(`REG_IRQ_STATUS, 8'h10, 8'h10, "reset_pool");
        rc(`REG_IRQ_STATUS, 8'h16, 8'h00, "irq_cleared");
    endtask

    task automatic t_ovf();
        wr(`REG_EXT_MODE, 8'h80);
        fill(17, 8'h00);
        rc(`REG_STATUS, 8'h10, 8'h00, "size_not_yet");
        cmd(8'h01);
        fill(16, 8'h00);
        rc(`REG_STATUS, 8'h10, 8'h00, "block16_full");
        fill(1, 8'h00);
        rc(`REG_STATUS, 8'h10, 8'h10, "block16_over");
        wr(`REG_EXT_MODE, 8'h00);
        cmd(8'h01);
        fill(32, 8'h00);
        rc(`REG_STATUS, 8'h10, 8'h00, "block32_full");
        fill(1, 8'h00);
        rc(`REG_STATUS, 8'h10, 8'h10, "block32_over");
        cmd(8'h01);
        clr_irq();
    endtask

    task automatic t_late();
        fill(32, 8'h40);
        cmd(8'h08);
        send(32);
        @(posedge clk);
        coll <= 1'b1;
        @(posedge clk);
        coll <= 1'b0;
        rc(`REG_IRQ_STATUS, 8'h16, 8'h12, "repeat_irq");
        cmd(8'h01);
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_idle();
        t_rx();
        t_rx_full();
        t_tx();
        t_under();
        t_tx_reset_cmd();
        t_ovf();
        t_late();
        conclude();
    end

    initial
    begin
        repeat (8000) @(posedge clk);
        err_count++;
        conclude();
    end
endmodule // testbench
`default_nettype wire
